// File: verilog/fbbp_host.sv
`timescale 1ns/1ps
`default_nettype none
module fbbp_host (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_byte_mode,
  input wire logic req_sig,
  input wire logic [18:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic [17:0] word_address_inputs,
  output logic signature_voltage_line,
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic output_strobe_n,
  output logic byte_word_select,
  input wire logic [15:0] lanes_in,
  output logic [14:0] lanes_out,
  output logic [14:0] lanes_oe,
  output logic top_lane_or_extra_address_out,
  output logic top_lane_or_extra_address_oe
);
  typedef enum logic [1:0] {FBBP_IDLE, FBBP_SETUP, FBBP_STROBE, FBBP_HOLD} fbbp_state_e;
  fbbp_state_e state;
  logic is_write;
  logic is_byte;
  logic [15:0] lanes_s1;
  logic [15:0] lanes_s2;
  logic tload;
  logic [3:0] tcount;
  logic tdone;
  logic take;
  logic setup_done;
  logic strobe_done;
  logic hold_done;

  assign take = (state == FBBP_IDLE) && req_valid;
  assign setup_done = (state == FBBP_SETUP) && tdone;
  assign strobe_done = (state == FBBP_STROBE) && tdone;
  assign hold_done = (state == FBBP_HOLD) && tdone;

  fbbp_timer u_timer (
    .mclk(mclk),
    .reset_n(reset_n),
    .load(tload),
    .count(tcount),
    .done(tdone)
  );

  // Lane input synchroniser
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lanes_s1 <= 16'h0000;
      lanes_s2 <= 16'h0000;
    end else begin
      lanes_s1 <= lanes_in;
      lanes_s2 <= lanes_s1;
    end
  end

  always_comb begin
    tload = 1'b0;
    tcount = 4'h0;
    unique case (state)
      FBBP_IDLE: begin
        tload = req_valid;
        tcount = 4'(fbbp_pkg::SETUP_CYC);
      end
      FBBP_SETUP: begin
        tload = tdone;
        tcount = is_write ? 4'(fbbp_pkg::STROBE_CYC) : 4'(fbbp_pkg::READ_CYC + 2);
      end
      FBBP_STROBE: begin
        tload = tdone;
        tcount = 4'(fbbp_pkg::HOLD_CYC);
      end
      FBBP_HOLD: begin
        tload = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= FBBP_IDLE;
    end else begin
      unique case (state)
        FBBP_IDLE: begin
          if (take) begin
            state <= FBBP_SETUP;
          end
        end
        FBBP_SETUP: begin
          if (tdone) begin
            state <= FBBP_STROBE;
          end
        end
        FBBP_STROBE: begin
          if (tdone) begin
            state <= FBBP_HOLD;
          end
        end
        FBBP_HOLD: begin
          if (tdone) begin
            state <= FBBP_IDLE;
          end
        end
      endcase
    end
  end

  // Transfer kind
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      is_write <= 1'b0;
      is_byte <= 1'b0;
    end else if (take) begin
      is_write <= req_write;
      is_byte <= req_byte_mode;
    end
  end

  // Address and signature pins, held until the next take
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      word_address_inputs <= 18'h00000;
      signature_voltage_line <= 1'b0;
    end else if (take) begin
      word_address_inputs <= req_addr[18:1];
      signature_voltage_line <= req_sig;
    end
  end

  // Organisation select
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      byte_word_select <= 1'b1;
    end else if (take) begin
      byte_word_select <= !req_byte_mode;
    end
  end

  // Write data lanes and top pin
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lanes_out <= 15'h0000;
      top_lane_or_extra_address_out <= 1'b0;
    end else if (take) begin
      if (req_byte_mode) begin
        lanes_out <= {7'h00, req_wdata[7:0]};
        top_lane_or_extra_address_out <= req_addr[0];
      end else begin
        lanes_out <= req_wdata[14:0];
        top_lane_or_extra_address_out <= req_wdata[15];
      end
    end
  end

  // Chip select, kept low through hold so the strobe rises first
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      chip_select_n <= 1'b1;
    end else if (setup_done) begin
      chip_select_n <= 1'b0;
    end else if (hold_done) begin
      chip_select_n <= 1'b1;
    end
  end

  // Write and output strobes
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      write_strobe_n <= 1'b1;
      output_strobe_n <= 1'b1;
    end else if (setup_done) begin
      write_strobe_n <= !is_write;
      output_strobe_n <= is_write;
    end else if (strobe_done) begin
      write_strobe_n <= 1'b1;
      output_strobe_n <= 1'b1;
    end
  end

  // Lane drive enables
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lanes_oe <= 15'h0000;
      top_lane_or_extra_address_oe <= 1'b0;
    end else if (take) begin
      lanes_oe <= req_write ? (req_byte_mode ? 15'h00ff : 15'h7fff) : 15'h0000;
      top_lane_or_extra_address_oe <= req_byte_mode || req_write;
    end else if (hold_done) begin
      lanes_oe <= 15'h0000;
      top_lane_or_extra_address_oe <= is_byte;
    end
  end

  // Read data valid pulse
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= strobe_done && !is_write;
    end
  end

  // Read data from the synchronised lanes at the end of the strobe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_rdata <= 16'h0000;
    end else if (strobe_done && !is_write) begin
      rsp_rdata <= is_byte ? {8'h00, lanes_s2[7:0]} : lanes_s2;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state == FBBP_IDLE) && !req_valid;
    end
  end
endmodule
`default_nettype wire

// File: verilog/fbbp_pkg.sv
`default_nettype none
package fbbp_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int CLK_NS = 40;
  // Setup of address/data before either strobe, strobe widths and hold time
  localparam int T_SETUP_NS = 40;
  localparam int T_STROBE_NS = 80;
  localparam int T_READ_NS = 120;
  localparam int T_HOLD_NS = 40;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYC = (T_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_SIG = 8'h90;
  typedef enum logic [1:0] {FBBP_SETUP, FBBP_STROBE, FBBP_HOLD} fbbp_phase_e;
endpackage
`default_nettype wire

// File: verilog/fbbp_timer.sv
`timescale 1ns/1ps
`default_nettype none
module fbbp_timer (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [3:0] count,
  output logic done
);
  logic [3:0] left;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      left <= 4'h0;
    end else if (load) begin
      left <= count;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end
  assign done = (left == 4'h0);
endmodule
`default_nettype wire

// File: sim/fbbp_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fbbp_sva (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_strobe_n,
  input wire logic byte_word_select,
  input wire logic [14:0] lanes_oe,
  input wire logic top_lane_or_extra_address_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence wr_pulse;
    !write_strobe_n [*3] ##1 write_strobe_n;
  endsequence
  sequence rd_pulse;
    !output_strobe_n [*6] ##1 output_strobe_n;
  endsequence
  chk_wr_width: assert property ($fell(write_strobe_n) |-> wr_pulse) else $error("wr width");
  chk_rd_width: assert property ($fell(output_strobe_n) |-> rd_pulse) else $error("rd width");
  chk_wr_select: assert property (!write_strobe_n |-> !chip_select_n) else $error("wr cs");
  chk_wr_release: assert property ($rose(write_strobe_n) |-> !chip_select_n) else $error("wr rel");
  chk_rd_float: assert property (!output_strobe_n |-> lanes_oe == 15'h0) else $error("fight");
  chk_no_both: assert property (write_strobe_n || output_strobe_n) else $error("both");
  chk_low_drive: assert property (!write_strobe_n |-> &lanes_oe[7:0]) else $error("low");
  chk_word_upper: assert property (!write_strobe_n && byte_word_select |-> &lanes_oe[14:8])
    else $error("upper");
  chk_byte_upper: assert property (!write_strobe_n && !byte_word_select |-> lanes_oe[14:8] == 7'h0)
    else $error("byte upper");
  chk_byte_addr: assert property (!chip_select_n && !byte_word_select
    |-> top_lane_or_extra_address_oe) else $error("top pin");
endmodule
bind fbbp_host fbbp_sva chk_u (.mclk, .reset_n, .chip_select_n, .write_strobe_n,
  .output_strobe_n, .byte_word_select, .lanes_oe, .top_lane_or_extra_address_oe);
`default_nettype wire

// File: sim/fbbp_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Identity code defaults are arbitrary
module fbbp_dev #(parameter logic [7:0] MAKER = 8'h5a, parameter logic [7:0] PART = 8'ha5) (
  input wire logic mclk,
  input wire logic [17:0] word_address_inputs,
  input wire logic signature_voltage_line,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_strobe_n,
  input wire logic byte_word_select,
  input wire logic [14:0] lanes_out,
  input wire logic [14:0] lanes_oe,
  input wire logic top_lane_or_extra_address_out,
  input wire logic top_lane_or_extra_address_oe,
  output logic [15:0] lanes_in
);
  logic [15:0] mem [0:15];
  logic [15:0] hd, hoe, rd;
  logic flip = 1'b0;
  logic [3:0] a;
  logic t;
  assign a = word_address_inputs[3:0];
  assign t = top_lane_or_extra_address_out;
  assign hd = {t, lanes_out};
  assign hoe = {top_lane_or_extra_address_oe, lanes_oe};
  always @(posedge mclk) flip <= ~flip;
  always @(posedge mclk) if (!chip_select_n && !write_strobe_n) begin
    if (byte_word_select) mem[a] <= hd;
    else mem[a][8*t +: 8] <= hd[7:0];
  end
  always_comb begin
    rd = mem[a];
    if (signature_voltage_line) rd = {8'h00, a[0] ? PART : MAKER};
    else if (!byte_word_select) rd = {8'h00, mem[a][8*t +: 8]};
  end
  always_comb
    for (int i = 0; i < 16; i++)
      if (hoe[i]) lanes_in[i] = hd[i];
      else if (!chip_select_n && !output_strobe_n && (byte_word_select || i < 8))
        lanes_in[i] = rd[i];
      else lanes_in[i] = flip ^ i[0];
endmodule
`default_nettype wire

// File: sim/tb_fbbp_host.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fbbp_host;
  logic mclk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic req_byte_mode = 1'b0, req_sig = 1'b0;
  logic [18:0] req_addr = 19'h0;
  logic [15:0] req_wdata = 16'h0, rsp_rdata, lanes_in;
  logic req_ready, rsp_valid, signature_voltage_line, chip_select_n, write_strobe_n;
  logic output_strobe_n, byte_word_select, top_lane_or_extra_address_out;
  logic top_lane_or_extra_address_oe;
  logic [17:0] word_address_inputs;
  logic [14:0] lanes_out, lanes_oe;
  int err_count = 0, cmp_count = 0, cyc = 0;
  fbbp_host dut_u (.*);
  fbbp_dev dev_u (.*);
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      conclude();
    end
  end
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task xfer(input logic w, b, s, input logic [18:0] ad, input logic [15:0] d,
    output logic [15:0] r);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin @(negedge mclk); n++; end
    {req_write, req_byte_mode, req_sig, req_addr, req_wdata} = {w, b, s, ad, d};
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    n = 0;
    while (!w && rsp_valid !== 1'b1 && n < 50) begin @(negedge mclk); n++; end
    r = rsp_rdata;
    if (n == 50) chk("rsp_valid", 16'h0, 16'h1);
  endtask
  task t_word;
    logic [15:0] r;
    xfer(1'b1, 1'b0, 1'b0, 19'ha, 16'hc3a5, r);
    xfer(1'b1, 1'b0, 1'b0, 19'hc, 16'h5a3c, r);
    xfer(1'b0, 1'b0, 1'b0, 19'ha, 16'h0, r);
    chk("word a", r, 16'hc3a5);
    xfer(1'b0, 1'b0, 1'b0, 19'hc, 16'h0, r);
    chk("word c", r, 16'h5a3c);
  endtask
  task t_byte;
    logic [15:0] r;
    xfer(1'b1, 1'b1, 1'b0, 19'h13, 16'h007e, r);
    xfer(1'b1, 1'b1, 1'b0, 19'h12, 16'h0081, r);
    xfer(1'b0, 1'b1, 1'b0, 19'h13, 16'h0, r);
    chk("byte hi", r, 16'h007e);
    xfer(1'b0, 1'b1, 1'b0, 19'h12, 16'h0, r);
    chk("byte lo", r, 16'h0081);
    xfer(1'b0, 1'b0, 1'b0, 19'h12, 16'h0, r);
    chk("byte word", r, 16'h7e81);
  endtask
  task t_sig;
    logic [15:0] r;
    for (int k = 0; k < 4; k++) begin
      xfer(1'b0, k[1], 1'b1, {17'h0, k[0], 1'b0}, 16'h0, r);
      chk("ident", r, {8'h00, k[0] ? 8'ha5 : 8'h5a});
    end
  endtask
  initial begin
    repeat (16) @(negedge mclk);
    reset_n = 1'b1;
    t_word();
    t_byte();
    t_sig();
    conclude();
  end
endmodule
`default_nettype wire
